// ---- exec_params.svh ----
// Constants for the arithmetic and branch execution core
`ifndef EXEC_PARAMS_SVH
`define EXEC_PARAMS_SVH

// ----------------------------------------------------------------
// Widths and reset values
// ----------------------------------------------------------------
`define PC_W 22
`define PC_RESET 22'h000000
`define STATUS_RESET 8'h00
`define EXT_IND_RESET 8'h00
`define BYTE_ALL 8'hFF
`define BYTE_NONE 8'h00

// ----------------------------------------------------------------
// Register port map (working registers sit at 0x00..0x1F)
// ----------------------------------------------------------------
`define ADDR_REG_TOP 7'h1F
`define ADDR_STATUS 7'h3F
`define ADDR_PC_LO 7'h40
`define ADDR_PC_MID 7'h41
`define ADDR_PC_HI 7'h42
`define ADDR_EXT_IND 7'h43

// ----------------------------------------------------------------
// Status register bit positions
// ----------------------------------------------------------------
`define FLAG_C 0
`define FLAG_Z 1
`define FLAG_N 2
`define FLAG_V 3
`define FLAG_S 4
`define FLAG_H 5
`define FLAG_T 6
`define FLAG_I 7

// ----------------------------------------------------------------
// Cycle counts per operation class
// ----------------------------------------------------------------
`define CYC_ONE 3'd1
`define CYC_WORD 3'd2
`define CYC_MUL 3'd2
`define CYC_REL_JUMP 3'd2
`define CYC_IND_JUMP 3'd2
`define CYC_DIR_JUMP 3'd3
`define CYC_REL_CALL 3'd4
`define CYC_IND_CALL 3'd4
`define CYC_DIR_CALL 3'd5
`define CYC_RETURN 3'd5
`define CYC_BR_TAKEN 3'd2
`define CYC_SKIP_ONE 3'd2
`define CYC_SKIP_TWO 3'd3

`endif

// ---- exec_pkg.sv ----
// Types shared by the execution core and its testbench
package exec_pkg;
	`include "exec_params.svh"

	typedef enum logic [5:0] {
		OP_NOP, OP_ADD, OP_ADD_CARRY, OP_ADD_IMM_WORD, OP_SUB, OP_SUB_CONST,
		OP_SUB_REGS_CARRY, OP_SUB_CONST_CARRY, OP_SUB_IMM_WORD, OP_AND, OP_AND_CONST,
		OP_OR, OP_OR_CONST, OP_XOR_REGS, OP_ONES_COMPLEMENT, OP_TWOS_COMPLEMENT,
		OP_SET_BITS_MASK, OP_CLEAR_BITS_MASK, OP_INCREMENT, OP_DECREMENT,
		OP_TEST_ZERO_MINUS, OP_CLEAR_REG, OP_SET_REGISTER_ALL,
		OP_MULTIPLY_UNSIGNED, OP_MULTIPLY_SIGNED, OP_MULTIPLY_SIGNED_UNSIGNED,
		OP_FRAC_MULTIPLY_UNSIGNED, OP_FRAC_MULTIPLY_SIGNED, OP_FRAC_MULTIPLY_MIXED,
		OP_RELATIVE_JUMP, OP_INDIRECT_JUMP, OP_EXTENDED_INDIRECT_JUMP, OP_DIRECT_JUMP,
		OP_RELATIVE_CALL, OP_INDIRECT_CALL, OP_EXTENDED_INDIRECT_CALL, OP_DIRECT_CALL,
		OP_RETURN, OP_INTERRUPT_RETURN, OP_COMPARE_SKIP_EQUAL, OP_COMPARE,
		OP_COMPARE_WITH_CARRY, OP_COMPARE_IMMEDIATE, OP_SKIP_REG_BIT_CLEAR,
		OP_SKIP_REG_BIT_SET, OP_SKIP_IO_BIT_CLEAR, OP_SKIP_IO_BIT_SET,
		OP_BRANCH_FLAG_SET, OP_BRANCH_FLAG_CLEAR, OP_BRANCH_EQUAL, OP_BRANCH_NOT_EQUAL,
		OP_BRANCH_CARRY_SET, OP_BRANCH_CARRY_CLEAR, OP_BRANCH_SAME_HIGHER,
		OP_BRANCH_LOWER, OP_BRANCH_MINUS, OP_BRANCH_PLUS
	} op_t;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b01,
		ST_BUSY = 2'b10
	} state_t;

	typedef struct packed {
		state_t st;
		logic [2:0] cnt;
		logic [31:0][7:0] regs;
		logic [`PC_W-1:0] pc;
		logic [7:0] status;
		logic [7:0] ext_ind;
		logic [7:0] rdata;
		logic push_valid;
		logic [`PC_W-1:0] push_pc;
	} core_t;
endpackage : exec_pkg

// ---- exec_mul.sv ----
// Eight by eight multiplier with signed, mixed and fractional forms
`timescale 1ns/1ps
module exec_mul (
	input wire logic [7:0] a,
	input wire logic [7:0] b,
	input wire logic a_signed,
	input wire logic b_signed,
	input wire logic frac,
	output logic [15:0] product,
	output logic carry
);
	logic signed [17:0] full;
	logic [15:0] raw;

	// Sign extend each operand by mode, then keep the low 16 bits
	always_comb begin
		full = $signed({{10{a_signed & a[7]}}, a})
			* $signed({{10{b_signed & b[7]}}, b});
		raw = full[15:0];
		carry = raw[15];
		// Fractional forms shift left by one; carry is taken before the shift
		product = frac ? {raw[14:0], 1'b0} : raw;
	end
endmodule : exec_mul

// ---- cpu_arith_branch_exec.sv ----
// Execution core for arithmetic, logic, multiply, jump, call, skip and branch
// What this block does
// - Add registers, optional carry, six flags, one cycle
// - Word add/subtract immediate on pair, two cycles
// - Byte subtract register or constant, one cycle
// - Logic ops update only Z, N, V, S
// - Mask clear/set and complements set flags; set-all without flags
// - Inc, dec, test, clear touch only Z,N,V,S
// - Multiplies write pair one:zero, Z and C
// - Fractional multiplies shift product left one
// - Indirect jumps load Z or extended target
// - Indirect calls load target, four cycles
// - Compare-skip-equal skips, no flag change
// - Compares set six flags, store nothing
// - Register bit skip on clear or set
// - I/O bit skip on clear or set
// - Flag branches jump PC plus offset plus one
// - Named branches test Z, C and N
// - Same-or-higher and lower follow carry branches
`timescale 1ns/1ps
`include "exec_params.svh"
module cpu_arith_branch_exec (
	input wire logic clk,
	input wire logic rst,
	input wire logic issue_valid,
	output logic issue_ready,
	input wire exec_pkg::op_t op,
	input wire logic [4:0] dst_sel,
	input wire logic [4:0] src_sel,
	input wire logic [7:0] imm,
	input wire logic [2:0] bit_sel,
	input wire logic [11:0] offset,
	input wire logic [21:0] target,
	input wire logic next_two_word,
	input wire logic io_bit,
	input wire logic [21:0] stack_pc,
	output logic pop_req,
	output logic push_valid,
	output logic [21:0] push_pc,
	output logic [21:0] pc,
	output logic [7:0] status,
	input wire logic [6:0] bus_addr,
	input wire logic [7:0] bus_wdata,
	input wire logic bus_wr,
	input wire logic bus_rd,
	output logic [7:0] bus_rdata
);
	import exec_pkg::*;

	// ----------------------------------------------------------------
	// Flag helpers
	// ----------------------------------------------------------------
	// Returns {h, v, c, result} of x + y + ci
	function automatic logic [10:0] add8(input logic [7:0] x, input logic [7:0] y,
			input logic ci);
		logic [7:0] r;
		r = x + y + {7'h00, ci};
		return {(x[3] & y[3]) | (y[3] & ~r[3]) | (~r[3] & x[3]),
			(x[7] & y[7] & ~r[7]) | (~x[7] & ~y[7] & r[7]),
			(x[7] & y[7]) | (y[7] & ~r[7]) | (~r[7] & x[7]), r};
	endfunction : add8

	// Returns {h, v, c, result} of x - y - ci
	function automatic logic [10:0] sub8(input logic [7:0] x, input logic [7:0] y,
			input logic ci);
		logic [7:0] r;
		r = x - y - {7'h00, ci};
		return {(~x[3] & y[3]) | (y[3] & r[3]) | (r[3] & ~x[3]),
			(x[7] & ~y[7] & ~r[7]) | (~x[7] & y[7] & r[7]),
			(~x[7] & y[7]) | (y[7] & r[7]) | (r[7] & ~x[7]), r};
	endfunction : sub8

	// Z, N, V and the derived sign flag S = N xor V
	function automatic logic [7:0] znv(input logic [7:0] st, input logic [7:0] r,
			input logic v);
		logic [7:0] o;
		o = st;
		o[`FLAG_Z] = (r == `BYTE_NONE);
		o[`FLAG_N] = r[7];
		o[`FLAG_V] = v;
		o[`FLAG_S] = r[7] ^ v;
		return o;
	endfunction : znv

	core_t s;
	core_t next_s;
	logic accept;
	logic [15:0] product;
	logic mul_carry;
	logic mul_a_signed;
	logic mul_b_signed;
	logic mul_frac;

	// ----------------------------------------------------------------
	// Issue handshake and outputs
	// ----------------------------------------------------------------
	// A new operation is taken only when the previous one has used its cycles
	assign issue_ready = (s.st == ST_IDLE);
	assign accept = issue_valid & issue_ready;
	assign pop_req = accept & (op == OP_RETURN || op == OP_INTERRUPT_RETURN);
	assign push_valid = s.push_valid;
	assign push_pc = s.push_pc;
	assign pc = s.pc;
	assign status = s.status;
	assign bus_rdata = s.rdata;

	// Multiplier mode decode
	always_comb begin
		mul_a_signed = (op == OP_MULTIPLY_SIGNED) || (op == OP_MULTIPLY_SIGNED_UNSIGNED)
			|| (op == OP_FRAC_MULTIPLY_SIGNED) || (op == OP_FRAC_MULTIPLY_MIXED);
		mul_b_signed = (op == OP_MULTIPLY_SIGNED) || (op == OP_FRAC_MULTIPLY_SIGNED);
		mul_frac = (op == OP_FRAC_MULTIPLY_UNSIGNED) || (op == OP_FRAC_MULTIPLY_SIGNED)
			|| (op == OP_FRAC_MULTIPLY_MIXED);
	end

	exec_mul u_mul (
		.a(s.regs[dst_sel]),
		.b(s.regs[src_sel]),
		.a_signed(mul_a_signed),
		.b_signed(mul_b_signed),
		.frac(mul_frac),
		.product(product),
		.carry(mul_carry)
	);

	// ----------------------------------------------------------------
	// Next-state logic
	// ----------------------------------------------------------------
	// Port writes land first so that an operation accepted in the same
	// cycle overrides them; the core's own result wins over a same-cycle port write.
	always_comb begin
		logic [7:0] a;
		logic [7:0] b;
		logic [7:0] st;
		logic [10:0] t;
		logic [15:0] w;
		logic [15:0] wr;
		logic [4:0] hi_sel;
		logic [2:0] cyc;
		logic [`PC_W-1:0] pc_next;
		logic [`PC_W-1:0] rel;
		logic [2:0] fsel;
		logic want;
		logic hit;
		a = s.regs[dst_sel];
		b = s.regs[src_sel];
		st = s.status;
		t = 11'h000;
		w = 16'h0000;
		wr = 16'h0000;
		hi_sel = 5'(dst_sel + 5'd1);
		cyc = `CYC_ONE;
		pc_next = s.pc + 22'd1;
		rel = s.pc + {{10{offset[11]}}, offset} + 22'd1;
		fsel = bit_sel;
		want = 1'b1;
		hit = 1'b0;
		next_s = s;
		next_s.push_valid = 1'b0;

		// Register port: write side
		if (bus_wr) begin
			if (bus_addr <= `ADDR_REG_TOP) next_s.regs[bus_addr[4:0]] = bus_wdata;
			else if (bus_addr == `ADDR_STATUS) next_s.status = bus_wdata;
			else if (bus_addr == `ADDR_PC_LO) next_s.pc[7:0] = bus_wdata;
			else if (bus_addr == `ADDR_PC_MID) next_s.pc[15:8] = bus_wdata;
			else if (bus_addr == `ADDR_PC_HI) next_s.pc[21:16] = bus_wdata[5:0];
			else if (bus_addr == `ADDR_EXT_IND) next_s.ext_ind = bus_wdata;
		end
		// Register port: read side, unmapped reads give zero
		if (bus_rd) begin
			if (bus_addr <= `ADDR_REG_TOP) next_s.rdata = s.regs[bus_addr[4:0]];
			else if (bus_addr == `ADDR_STATUS) next_s.rdata = s.status;
			else if (bus_addr == `ADDR_PC_LO) next_s.rdata = s.pc[7:0];
			else if (bus_addr == `ADDR_PC_MID) next_s.rdata = s.pc[15:8];
			else if (bus_addr == `ADDR_PC_HI) next_s.rdata = {2'b00, s.pc[21:16]};
			else if (bus_addr == `ADDR_EXT_IND) next_s.rdata = s.ext_ind;
			else next_s.rdata = `BYTE_NONE;
		end

		if (accept) begin
			case (op)
				OP_ADD, OP_ADD_CARRY: begin
					t = add8(a, b, (op == OP_ADD_CARRY) & s.status[`FLAG_C]);
					st = znv(st, t[7:0], t[9]);
					st[`FLAG_C] = t[8];
					st[`FLAG_H] = t[10];
					next_s.regs[dst_sel] = t[7:0];
				end
				OP_ADD_IMM_WORD, OP_SUB_IMM_WORD: begin
					// The pair is one 16-bit value; the constant is six bits wide
					wr = {s.regs[hi_sel], a};
					w = (op == OP_ADD_IMM_WORD) ? wr + {10'h000, imm[5:0]}
						: wr - {10'h000, imm[5:0]};
					st[`FLAG_Z] = (w == 16'h0000);
					st[`FLAG_N] = w[15];
					if (op == OP_ADD_IMM_WORD) begin
						st[`FLAG_V] = ~wr[15] & w[15];
						st[`FLAG_C] = ~w[15] & wr[15];
					end else begin
						st[`FLAG_V] = wr[15] & ~w[15];
						st[`FLAG_C] = w[15] & ~wr[15];
					end
					st[`FLAG_S] = st[`FLAG_N] ^ st[`FLAG_V];
					next_s.regs[dst_sel] = w[7:0];
					next_s.regs[hi_sel] = w[15:8];
					cyc = `CYC_WORD;
				end
				OP_SUB, OP_SUB_CONST, OP_SUB_REGS_CARRY, OP_SUB_CONST_CARRY,
				OP_TWOS_COMPLEMENT, OP_COMPARE, OP_COMPARE_WITH_CARRY,
				OP_COMPARE_IMMEDIATE: begin
					if (op == OP_SUB_CONST || op == OP_SUB_CONST_CARRY
							|| op == OP_COMPARE_IMMEDIATE) b = imm;
					if (op == OP_TWOS_COMPLEMENT) t = sub8(`BYTE_NONE, a, 1'b0);
					else t = sub8(a, b, s.status[`FLAG_C] & (op == OP_SUB_REGS_CARRY
						|| op == OP_SUB_CONST_CARRY || op == OP_COMPARE_WITH_CARRY));
					st = znv(st, t[7:0], t[9]);
					st[`FLAG_C] = t[8];
					st[`FLAG_H] = t[10];
					// Carry forms chain over multiple bytes: zero only stays set
					if (op == OP_SUB_REGS_CARRY || op == OP_SUB_CONST_CARRY
							|| op == OP_COMPARE_WITH_CARRY)
						st[`FLAG_Z] = st[`FLAG_Z] & s.status[`FLAG_Z];
					// Compares keep the difference out of the register file
					if (op != OP_COMPARE && op != OP_COMPARE_WITH_CARRY
							&& op != OP_COMPARE_IMMEDIATE)
						next_s.regs[dst_sel] = t[7:0];
				end
				OP_AND, OP_AND_CONST, OP_OR, OP_OR_CONST, OP_XOR_REGS, OP_SET_BITS_MASK,
				OP_CLEAR_BITS_MASK, OP_TEST_ZERO_MINUS, OP_CLEAR_REG: begin
					case (op)
						OP_AND: t[7:0] = a & b;
						OP_AND_CONST: t[7:0] = a & imm;
						OP_OR: t[7:0] = a | b;
						OP_OR_CONST, OP_SET_BITS_MASK: t[7:0] = a | imm;
						OP_XOR_REGS: t[7:0] = a ^ b;
						OP_CLEAR_BITS_MASK: t[7:0] = a & (`BYTE_ALL - imm);
						OP_TEST_ZERO_MINUS: t[7:0] = a & a;
						default: t[7:0] = a ^ a;
					endcase
					st = znv(st, t[7:0], 1'b0);
					next_s.regs[dst_sel] = t[7:0];
				end
				OP_ONES_COMPLEMENT: begin
					t[7:0] = `BYTE_ALL - a;
					st = znv(st, t[7:0], 1'b0);
					st[`FLAG_C] = 1'b1;
					next_s.regs[dst_sel] = t[7:0];
				end
				OP_INCREMENT, OP_DECREMENT: begin
					t[7:0] = (op == OP_INCREMENT) ? a + 8'h01 : a - 8'h01;
					st = znv(st, t[7:0], (op == OP_INCREMENT) ? (t[7:0] == 8'h80)
						: (t[7:0] == 8'h7F));
					next_s.regs[dst_sel] = t[7:0];
				end
				OP_SET_REGISTER_ALL: next_s.regs[dst_sel] = `BYTE_ALL;
				OP_MULTIPLY_UNSIGNED, OP_MULTIPLY_SIGNED, OP_MULTIPLY_SIGNED_UNSIGNED,
				OP_FRAC_MULTIPLY_UNSIGNED, OP_FRAC_MULTIPLY_SIGNED,
				OP_FRAC_MULTIPLY_MIXED: begin
					next_s.regs[1] = product[15:8];
					next_s.regs[0] = product[7:0];
					st[`FLAG_Z] = (product == 16'h0000);
					st[`FLAG_C] = mul_carry;
					cyc = `CYC_MUL;
				end
				OP_RELATIVE_JUMP: begin
					pc_next = rel;
					cyc = `CYC_REL_JUMP;
				end
				OP_DIRECT_JUMP: begin
					pc_next = target;
					cyc = `CYC_DIR_JUMP;
				end
				OP_INDIRECT_JUMP, OP_EXTENDED_INDIRECT_JUMP, OP_INDIRECT_CALL,
				OP_EXTENDED_INDIRECT_CALL: begin
					// The extended form places the low six bits of the extension byte above Z
					pc_next = {((op == OP_EXTENDED_INDIRECT_JUMP
						|| op == OP_EXTENDED_INDIRECT_CALL) ? s.ext_ind[5:0] : 6'h00),
						s.regs[31], s.regs[30]};
					cyc = `CYC_IND_JUMP;
					if (op == OP_INDIRECT_CALL || op == OP_EXTENDED_INDIRECT_CALL) begin
						cyc = `CYC_IND_CALL;
						next_s.push_valid = 1'b1;
						next_s.push_pc = s.pc + 22'd1;
					end
				end
				OP_RELATIVE_CALL, OP_DIRECT_CALL: begin
					// The direct form is two words long, so it returns past both
					next_s.push_valid = 1'b1;
					next_s.push_pc = (op == OP_DIRECT_CALL) ? s.pc + 22'd2 : s.pc + 22'd1;
					pc_next = (op == OP_DIRECT_CALL) ? target : rel;
					cyc = (op == OP_DIRECT_CALL) ? `CYC_DIR_CALL : `CYC_REL_CALL;
				end
				OP_RETURN, OP_INTERRUPT_RETURN: begin
					pc_next = stack_pc;
					cyc = `CYC_RETURN;
					if (op == OP_INTERRUPT_RETURN) st[`FLAG_I] = 1'b1;
				end
				OP_COMPARE_SKIP_EQUAL, OP_SKIP_REG_BIT_CLEAR, OP_SKIP_REG_BIT_SET,
				OP_SKIP_IO_BIT_CLEAR, OP_SKIP_IO_BIT_SET: begin
					case (op)
						OP_COMPARE_SKIP_EQUAL: hit = (a == b);
						OP_SKIP_REG_BIT_CLEAR: hit = ~b[bit_sel];
						OP_SKIP_REG_BIT_SET: hit = b[bit_sel];
						OP_SKIP_IO_BIT_CLEAR: hit = ~io_bit;
						default: hit = io_bit;
					endcase
					// Skipping a two-word instruction costs one cycle more
					if (hit) begin
						pc_next = s.pc + (next_two_word ? 22'd3 : 22'd2);
						cyc = next_two_word ? `CYC_SKIP_TWO : `CYC_SKIP_ONE;
					end
				end
				OP_BRANCH_FLAG_SET, OP_BRANCH_FLAG_CLEAR, OP_BRANCH_EQUAL,
				OP_BRANCH_NOT_EQUAL, OP_BRANCH_CARRY_SET, OP_BRANCH_CARRY_CLEAR,
				OP_BRANCH_SAME_HIGHER, OP_BRANCH_LOWER, OP_BRANCH_MINUS,
				OP_BRANCH_PLUS: begin
					case (op)
						OP_BRANCH_FLAG_CLEAR: want = 1'b0;
						OP_BRANCH_EQUAL: fsel = 3'(`FLAG_Z);
						OP_BRANCH_NOT_EQUAL: begin
							fsel = 3'(`FLAG_Z);
							want = 1'b0;
						end
						OP_BRANCH_CARRY_SET, OP_BRANCH_LOWER: fsel = 3'(`FLAG_C);
						OP_BRANCH_CARRY_CLEAR, OP_BRANCH_SAME_HIGHER: begin
							fsel = 3'(`FLAG_C);
							want = 1'b0;
						end
						OP_BRANCH_MINUS: fsel = 3'(`FLAG_N);
						OP_BRANCH_PLUS: begin
							fsel = 3'(`FLAG_N);
							want = 1'b0;
						end
						default: want = 1'b1;
					endcase
					if (s.status[fsel] == want) begin
						pc_next = rel;
						cyc = `CYC_BR_TAKEN;
					end
				end
				default: cyc = `CYC_ONE;
			endcase
			next_s.status = st;
			next_s.pc = pc_next;
		end

		// Cycle sequencer: holds the issue port for the rest of the count
		case (s.st)
			ST_IDLE: begin
				if (accept && cyc > `CYC_ONE) begin
					next_s.st = ST_BUSY;
					next_s.cnt = 3'(cyc - `CYC_ONE);
				end
			end
			ST_BUSY: begin
				next_s.cnt = s.cnt - 3'd1;
				if (s.cnt == 3'd1) next_s.st = ST_IDLE;
			end
			default: begin
				next_s.st = ST_IDLE;
				next_s.cnt = 3'd0;
			end
		endcase
	end

	// State register
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			s <= '{st: ST_IDLE, cnt: 3'd0, regs: '0, pc: `PC_RESET, status: `STATUS_RESET,
				ext_ind: `EXT_IND_RESET, rdata: `BYTE_NONE, push_valid: 1'b0,
				push_pc: `PC_RESET};
		end else begin
			s <= next_s;
		end
	end

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	// Snapshot of the accepted operation for checks one cycle later
	logic h_acc;
	op_t h_op;
	logic [4:0] h_d;
	logic [7:0] h_a;
	logic [7:0] h_b;
	logic [7:0] h_st;
	logic [21:0] h_pc;
	logic [21:0] h_k;
	logic [2:0] h_bit;
	logic [15:0] h_z;
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			h_acc <= 1'b0;
			h_op <= OP_NOP;
			h_d <= 5'd0;
			h_a <= 8'h00;
			h_b <= 8'h00;
			h_st <= 8'h00;
			h_pc <= 22'h000000;
			h_k <= 22'h000000;
			h_bit <= 3'd0;
			h_z <= 16'h0000;
		end else begin
			h_acc <= accept;
			h_op <= op;
			h_d <= dst_sel;
			h_a <= s.regs[dst_sel];
			h_b <= s.regs[src_sel];
			h_st <= s.status;
			h_pc <= s.pc;
			h_k <= {{10{offset[11]}}, offset};
			h_bit <= bit_sel;
			h_z <= {s.regs[31], s.regs[30]};
		end
	end

	add_sum_a: assert property (@(posedge clk) disable iff (rst)
		h_acc && h_op == OP_ADD |-> s.regs[h_d] == 8'(h_a + h_b))
		else $error("add result wrong");
	word_timing_a: assert property (@(posedge clk) disable iff (rst)
		accept && op == OP_ADD_IMM_WORD |=> !issue_ready ##1 issue_ready)
		else $error("word add not two cycles");
	sub_carry_a: assert property (@(posedge clk) disable iff (rst)
		h_acc && h_op == OP_SUB |-> s.status[`FLAG_C] == (h_b > h_a))
		else $error("subtract borrow wrong");
	logic_carry_a: assert property (@(posedge clk) disable iff (rst)
		h_acc && (h_op == OP_AND || h_op == OP_XOR_REGS)
		|-> s.status[`FLAG_C] == h_st[`FLAG_C] && s.status[`FLAG_H] == h_st[`FLAG_H])
		else $error("logic op touched carry");
	set_all_a: assert property (@(posedge clk) disable iff (rst)
		h_acc && h_op == OP_SET_REGISTER_ALL |-> s.regs[h_d] == 8'hFF && s.status == h_st)
		else $error("set all wrong");
	mul_product_a: assert property (@(posedge clk) disable iff (rst)
		h_acc && h_op == OP_MULTIPLY_UNSIGNED
		|-> {s.regs[1], s.regs[0]} == {8'h00, h_a} * {8'h00, h_b})
		else $error("unsigned product wrong");
	jump_target_a: assert property (@(posedge clk) disable iff (rst)
		h_acc && h_op == OP_INDIRECT_JUMP |-> s.pc == {6'h00, h_z})
		else $error("indirect jump target wrong");
	call_timing_a: assert property (@(posedge clk) disable iff (rst)
		accept && op == OP_INDIRECT_CALL |=> !issue_ready [*3] ##1 issue_ready)
		else $error("indirect call not four cycles");
	skip_flags_a: assert property (@(posedge clk) disable iff (rst)
		h_acc && h_op == OP_COMPARE_SKIP_EQUAL |-> s.status == h_st)
		else $error("skip changed flags");
	branch_taken_a: assert property (@(posedge clk) disable iff (rst)
		h_acc && h_op == OP_BRANCH_FLAG_SET && h_st[h_bit] |-> s.pc == h_pc + h_k + 22'd1)
		else $error("taken branch target wrong");
	interrupt_return_flag_a: assert property (@(posedge clk) disable iff (rst)
		h_acc && h_op == OP_INTERRUPT_RETURN |-> s.status[`FLAG_I])
		else $error("interrupt return left I clear");
endmodule : cpu_arith_branch_exec

// ---- cpu_arith_branch_exec_tb.sv ----
// Self-checking testbench for the arithmetic and branch execution core
`timescale 1ns/1ps
module cpu_arith_branch_exec_tb;
	import exec_pkg::*;
	logic clk = 0, rst = 1, issue_valid = 0, next_two_word = 0, io_bit = 0, bus_wr = 0, bus_rd = 0;
	logic issue_ready, pop_req, push_valid, pr, pv;
	op_t op = OP_NOP;
	logic [4:0] dst_sel = 0, src_sel = 0;
	logic [7:0] imm = 0, bus_wdata = 0, status, bus_rdata;
	logic [2:0] bit_sel = 0;
	logic [11:0] offset = 0;
	logic [21:0] target = 0, stack_pc = 0, push_pc, pc, p0, pp;
	logic [6:0] bus_addr = 0;
	op_t bops[10] = '{OP_BRANCH_EQUAL, OP_BRANCH_NOT_EQUAL, OP_BRANCH_CARRY_SET,
		OP_BRANCH_CARRY_CLEAR, OP_BRANCH_SAME_HIGHER, OP_BRANCH_LOWER, OP_BRANCH_MINUS,
		OP_BRANCH_PLUS, OP_BRANCH_FLAG_SET, OP_BRANCH_FLAG_CLEAR};
	logic [9:0] btk = 10'b0101100110;
	int n_fail = 0, compares = 0;

	cpu_arith_branch_exec DUT (.clk(clk), .rst(rst), .issue_valid(issue_valid),
		.issue_ready(issue_ready), .op(op), .dst_sel(dst_sel), .src_sel(src_sel), .imm(imm),
		.bit_sel(bit_sel), .offset(offset), .target(target), .next_two_word(next_two_word),
		.io_bit(io_bit), .stack_pc(stack_pc), .pop_req(pop_req), .push_valid(push_valid),
		.push_pc(push_pc), .pc(pc), .status(status), .bus_addr(bus_addr),
		.bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata));

	// 25 MHz clock
	always #20 clk = ~clk;

	// ----------------------------------------------------------------
	// Comparison and closing tasks
	// ----------------------------------------------------------------
	task automatic chk_byte(input logic [7:0] g, input logic [7:0] e);
		compares++;
		if (g !== e) begin
			n_fail++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask : chk_byte

	task automatic chk_pc(input logic [21:0] g, input logic [21:0] e);
		compares++;
		if (g !== e) begin
			n_fail++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask : chk_pc

	task automatic tally_and_finish();
		$display("n_fail=%0d compares=%0d", n_fail, compares);
		if (n_fail == 0 && compares > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask : tally_and_finish

	// ----------------------------------------------------------------
	// Register port and issue port drivers
	// ----------------------------------------------------------------
	task automatic bus_w(input logic [6:0] a, input logic [7:0] d);
		@(posedge clk);
		bus_wr <= 1;
		bus_addr <= a;
		bus_wdata <= d;
		@(posedge clk);
		bus_wr <= 0;
	endtask : bus_w

	// Read data are registered and appear in the cycle after the strobe, so sample there
	task automatic bus_r(input logic [6:0] a, input logic [7:0] e);
		@(posedge clk);
		bus_rd <= 1;
		bus_addr <= a;
		@(posedge clk);
		bus_rd <= 0;
		@(negedge clk);
		chk_byte(bus_rdata, e);
	endtask : bus_r

	// One operation; k feeds imm, offset, target and stack_pc; f is {two word, io bit}.
	// Checks the busy span against cyc, bounded so a stuck core cannot hang us.
	task automatic issue(input op_t o, input logic [4:0] d, input logic [4:0] r,
		input logic [21:0] k, input logic [2:0] b, input logic [1:0] f, input int cyc);
		int n;
		@(negedge clk);
		p0 = pc;
		@(posedge clk);
		issue_valid <= 1;
		op <= o;
		dst_sel <= d;
		src_sel <= r;
		imm <= k[7:0];
		offset <= k[11:0];
		target <= k;
		stack_pc <= k;
		bit_sel <= b;
		next_two_word <= f[1];
		io_bit <= f[0];
		@(negedge clk);
		pr = pop_req;
		@(posedge clk);
		issue_valid <= 0;
		@(negedge clk);
		pv = push_valid;
		pp = push_pc;
		n = 1;
		while (issue_ready !== 1'b1 && n < 9) begin
			@(negedge clk);
			n++;
		end
		chk_pc(22'(n), 22'(cyc));
	endtask : issue

	// Watchdog: the sequence needs well under a thousand cycles
	initial begin
		#200us;
		n_fail++;
		tally_and_finish();
	end

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial begin
		repeat (4) @(posedge clk);
		rst <= 0;
		bus_r(7'h3F, 8'h00);
		chk_pc(pc, 22'h000000);
		bus_w(7'h02, 8'h80);
		bus_w(7'h03, 8'h80);
		issue(OP_ADD, 2, 3, 0, 0, 0, 1);
		bus_r(7'h02, 8'h00);
		chk_byte(status, 8'h1B);
		chk_pc(pc, p0 + 22'h000001);
		bus_w(7'h02, 8'h0F);
		issue(OP_ADD_CARRY, 2, 3, 0, 0, 0, 1);
		bus_r(7'h02, 8'h90);
		chk_byte(status, 8'h34);
		issue(OP_SUB_CONST, 4, 0, 22'h000001, 0, 0, 1);
		bus_r(7'h04, 8'hFF);
		chk_byte(status, 8'h35);
		issue(OP_XOR_REGS, 4, 4, 0, 0, 0, 1);
		bus_r(7'h04, 8'h00);
		chk_byte(status, 8'h23);
		issue(OP_SET_REGISTER_ALL, 5, 0, 0, 0, 0, 1);
		bus_r(7'h05, 8'hFF);
		bus_r(7'h50, 8'h00);
		chk_byte(status, 8'h23);
		issue(OP_CLEAR_BITS_MASK, 5, 0, 22'h00000F, 0, 0, 1);
		bus_r(7'h05, 8'hF0);
		chk_byte(status, 8'h35);
		issue(OP_MULTIPLY_UNSIGNED, 5, 5, 0, 0, 0, 2);
		bus_r(7'h01, 8'hE1);
		bus_r(7'h00, 8'h00);
		issue(OP_FRAC_MULTIPLY_UNSIGNED, 5, 5, 0, 0, 0, 2);
		bus_r(7'h01, 8'hC2);
		chk_byte(status, 8'h35);
		bus_w(7'h18, 8'hFF);
		bus_w(7'h19, 8'h7F);
		issue(OP_ADD_IMM_WORD, 24, 0, 22'h000001, 0, 0, 2);
		bus_r(7'h18, 8'h00);
		bus_r(7'h19, 8'h80);
		chk_byte(status, 8'h2C);
		bus_w(7'h06, 8'h10);
		bus_w(7'h07, 8'h20);
		issue(OP_COMPARE, 6, 7, 0, 0, 0, 1);
		chk_byte(status, 8'h15);
		bus_r(7'h06, 8'h10);
		issue(OP_SUB, 8, 7, 0, 0, 0, 1);
		bus_r(7'h08, 8'hE0);
		issue(OP_COMPARE_SKIP_EQUAL, 6, 6, 0, 0, 2'b00, 2);
		chk_pc(pc, p0 + 22'h000002);
		issue(OP_COMPARE_SKIP_EQUAL, 6, 6, 0, 0, 2'b10, 3);
		chk_pc(pc, p0 + 22'h000003);
		issue(OP_SKIP_REG_BIT_SET, 0, 6, 0, 4, 2'b00, 2);
		chk_pc(pc, p0 + 22'h000002);
		issue(OP_SKIP_REG_BIT_CLEAR, 0, 6, 0, 4, 2'b00, 1);
		issue(OP_SKIP_IO_BIT_CLEAR, 0, 0, 0, 0, 2'b00, 2);
		chk_pc(pc, p0 + 22'h000002);
		issue(OP_SKIP_IO_BIT_SET, 0, 0, 0, 0, 2'b00, 1);
		chk_byte(status, 8'h15);
		// Status holds C and N set, Z clear; a negative offset checks sign extension
		for (int i = 0; i < 10; i++) begin
			issue(bops[i], 0, 0, 22'h000FF0, 0, 0, btk[i] ? 2 : 1);
			chk_pc(pc, p0 + (btk[i] ? 22'h3FFFF1 : 22'h000001));
		end
		bus_w(7'h1E, 8'h34);
		bus_w(7'h1F, 8'h12);
		bus_w(7'h43, 8'h01);
		issue(OP_INDIRECT_JUMP, 0, 0, 0, 0, 0, 2);
		chk_pc(pc, 22'h001234);
		issue(OP_EXTENDED_INDIRECT_JUMP, 0, 0, 0, 0, 0, 2);
		chk_pc(pc, 22'h011234);
		issue(OP_INDIRECT_CALL, 0, 0, 0, 0, 0, 4);
		chk_pc(pc, 22'h001234);
		chk_pc(pp, p0 + 22'h000001);
		issue(OP_EXTENDED_INDIRECT_CALL, 0, 0, 0, 0, 0, 4);
		chk_pc(pc, 22'h011234);
		chk_pc(22'(pv), 22'h000001);
		issue(OP_RELATIVE_JUMP, 0, 0, 22'h000010, 0, 0, 2);
		chk_pc(pc, p0 + 22'h000011);
		issue(OP_DIRECT_JUMP, 0, 0, 22'h2ABCDE, 0, 0, 3);
		chk_pc(pc, 22'h2ABCDE);
		issue(OP_RELATIVE_CALL, 0, 0, 22'h000010, 0, 0, 4);
		chk_pc(pp, p0 + 22'h000001);
		issue(OP_DIRECT_CALL, 0, 0, 22'h155555, 0, 0, 5);
		chk_pc(pc, 22'h155555);
		chk_pc(pp, p0 + 22'h000002);
		issue(OP_RETURN, 0, 0, 22'h0ABCDE, 0, 0, 5);
		chk_pc(pc, 22'h0ABCDE);
		chk_pc(22'(pr), 22'h000001);
		issue(OP_INTERRUPT_RETURN, 0, 0, 22'h012345, 0, 0, 5);
		chk_pc(pc, 22'h012345);
		bus_r(7'h3F, 8'h95);
		bus_r(7'h40, 8'h45);
		issue(OP_SUB_REGS_CARRY, 2, 3, 0, 0, 0, 1);
		chk_byte(status, 8'hA0);
		issue(OP_COMPARE_WITH_CARRY, 2, 2, 0, 0, 0, 1);
		chk_byte(status, 8'h80);
		issue(OP_COMPARE_IMMEDIATE, 2, 0, 22'h0F, 0, 0, 1);
		chk_byte(status, 8'h82);
		issue(OP_SUB_CONST_CARRY, 2, 0, 22'h10, 0, 0, 1);
		chk_byte(status, 8'h95);
		issue(OP_SUB_IMM_WORD, 24, 0, 22'h01, 0, 0, 2);
		chk_byte(status, 8'h98);
		issue(OP_AND, 5, 6, 0, 0, 0, 1);
		issue(OP_OR, 5, 7, 0, 0, 0, 1);
		issue(OP_AND_CONST, 5, 0, 22'h21, 0, 0, 1);
		issue(OP_OR_CONST, 5, 0, 22'h81, 0, 0, 1);
		issue(OP_SET_BITS_MASK, 5, 0, 22'h0E, 0, 0, 1);
		bus_r(7'h05, 8'hAF);
		issue(OP_TEST_ZERO_MINUS, 4, 0, 0, 0, 0, 1);
		chk_byte(status, 8'h82);
		issue(OP_CLEAR_REG, 5, 0, 0, 0, 0, 1);
		bus_r(7'h05, 8'h00);
		issue(OP_INCREMENT, 25, 0, 0, 0, 0, 1);
		chk_byte(status, 8'h8C);
		issue(OP_DECREMENT, 25, 0, 0, 0, 0, 1);
		chk_byte(status, 8'h98);
		issue(OP_ONES_COMPLEMENT, 25, 0, 0, 0, 0, 1);
		chk_byte(status, 8'h95);
		issue(OP_TWOS_COMPLEMENT, 25, 0, 0, 0, 0, 1);
		chk_byte(status, 8'h8D);
		issue(OP_MULTIPLY_SIGNED, 25, 6, 0, 0, 0, 2);
		bus_r(7'h01, 8'hF8);
		issue(OP_MULTIPLY_SIGNED_UNSIGNED, 6, 25, 0, 0, 0, 2);
		bus_r(7'h01, 8'h08);
		issue(OP_FRAC_MULTIPLY_SIGNED, 25, 25, 0, 0, 0, 2);
		bus_r(7'h01, 8'h80);
		issue(OP_FRAC_MULTIPLY_MIXED, 25, 25, 0, 0, 0, 2);
		chk_byte(status, 8'h8D);
		tally_and_finish();
	end
endmodule : cpu_arith_branch_exec_tb
